// [design/conversion_run_bit_top.sv]
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
module conversion_run_bit_top
  import conversion_run_bit_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ce_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // analog front end
  input  wire logic        cmp_i,
  input  wire logic        stop_mode_i,
  output logic      [9:0]  dac_code_o,
  output logic             sample_o,
  output logic      [1:0]  channel_o,
  output logic             irq_o
);
  conversion_run_bit_state_type state, next_state;
  conversion_run_bit_mode_type  mode, next_mode;
  conversion_run_bit_acc_type   acc, next_acc;
  logic [1:0]       chan, next_chan;
  logic [1:0]       stat, next_stat;
  logic [1:0]       mask, next_mask;
  logic [RES_W-1:0] result, next_result;
  logic [RES_W-1:0] sar, next_sar;
  logic [3:0]       idx, next_idx;
  logic [7:0]       cnt, next_cnt;
  logic [7:0]       warm, next_warm;
  logic             first_bad, next_first_bad;
  logic [31:0]      rdata, next_rdata;
  logic             sample, next_sample;
  logic             irq, next_irq;
  logic             take, wr_mode, wr_chan, wr_cfg, warm_ok, step, done, run_now;
  logic [RES_W-1:0] sar_kept;

  always_comb begin
    take    = hsel_i && htrans_i[1] && hready_i;
    wr_mode = acc.vld && acc.wr && (acc.addr == MODE_OFS);
    wr_chan = acc.vld && acc.wr && (acc.addr == CHAN_OFS);
    wr_cfg  = wr_mode || wr_chan;
    warm_ok = (warm == WARM_CYC);
    step    = (state == ST_CONV) && (cnt == BIT_LAST);
    done    = step && (idx == 4'h0);
    run_now = wr_mode ? hwdata_i[RUN_BIT] : mode.run;
    sar_kept = cmp_i ? sar : (sar & ~(10'h001 << idx));
  end

  always_comb begin
    next_state     = state;
    next_mode      = mode;
    next_acc       = acc;
    next_chan      = chan;
    next_stat      = stat;
    next_mask      = mask;
    next_result    = result;
    next_sar       = sar;
    next_idx       = idx;
    next_cnt       = cnt;
    next_warm      = warm;
    next_first_bad = first_bad;
    next_rdata     = rdata;
    // bus: address phase
    next_acc = '{vld: take, wr: hwrite_i, addr: haddr_i[7:0]};
    if (take && !hwrite_i) begin
      // read sees the value before any same-cycle store
      case (haddr_i[7:0])
        MODE_OFS:   next_rdata = {24'h000000, mode};
        CHAN_OFS:   next_rdata = {30'h00000000, chan};
        RFULL_OFS:  next_rdata = {22'h000000, result};
        RUPPER_OFS: next_rdata = {24'h000000, result[9:2]};
        STAT_OFS:   next_rdata = {30'h00000000, stat};
        MASK_OFS:   next_rdata = {30'h00000000, mask};
        default:    next_rdata = 32'h00000000;
      endcase
      if (haddr_i[7:0] == STAT_OFS) begin
        next_stat = STAT_RST;
      end
    end
    // bus: data phase writes; channel write leaves flag alone
    if (wr_mode) begin
      next_mode = conversion_run_bit_mode_type'(hwdata_i[7:0] & MODE_WMASK);
    end
    if (wr_chan) begin
      next_chan = hwdata_i[1:0];
    end
    if (acc.vld && acc.wr && (acc.addr == MASK_OFS)) begin
      next_mask = hwdata_i[1:0];
    end
    // settling after power enable
    if (!mode.ena) begin
      next_warm = 8'h00;
    end else if (!warm_ok) begin
      next_warm = warm + 8'h01;
    end
    // converter sequence
    case (state)
      ST_IDLE: begin
        if (mode.run && !stop_mode_i) begin
          next_state     = ST_SAMPLE;
          next_cnt       = 8'h00;
          next_first_bad = !warm_ok;
        end
      end
      ST_SAMPLE: begin
        // sample window (fr+1)*8 cycles counts into conversion time
        if (cnt == {2'b00, mode.fr, 3'b111}) begin
          next_state = ST_CONV;
          next_cnt   = 8'h00;
          next_sar   = SAR_MSB_SET;
          next_idx   = IDX_MSB;
        end else begin
          next_cnt = cnt + 8'h01;
        end
      end
      ST_CONV: begin
        next_cnt = cnt + 8'h01;
        if (step) begin
          next_cnt = 8'h00;
          if (done) begin
            next_sar   = sar_kept;
            next_state = ST_SAMPLE;
            if (!wr_cfg) begin
              // a config write in this cycle suppresses the store and the end flag
              next_result = sar_kept;
              next_stat[ST_END] = 1'b1;
              if (first_bad) begin
                next_stat[ST_SUSP] = 1'b1;
              end
            end
            next_first_bad = 1'b0;
          end else begin
            next_sar = sar_kept | (10'h001 << (idx - 4'h1));
            next_idx = idx - 4'h1;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // config write aborts, and restarts if the run bit is set, else goes idle; result may be stale afterwards
    if (wr_cfg) begin
      next_state     = run_now ? ST_SAMPLE : ST_IDLE;
      next_cnt       = 8'h00;
      next_first_bad = !warm_ok;
    end
    if (!run_now) begin
      next_state = ST_IDLE;
    end
    if (stop_mode_i) begin
      next_state = ST_IDLE;
    end
    next_sample = (next_state == ST_SAMPLE);
    next_irq    = |(next_stat & next_mask);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state     <= ST_IDLE;
      mode      <= conversion_run_bit_mode_type'(MODE_RST);
      acc       <= '0;
      chan      <= CHAN_RST;
      stat      <= STAT_RST;
      mask      <= MASK_RST;
      result    <= '0;
      sar       <= '0;
      idx       <= 4'h0;
      cnt       <= 8'h00;
      warm      <= 8'h00;
      first_bad <= 1'b0;
      rdata     <= 32'h00000000;
      sample    <= 1'b0;
      irq       <= 1'b0;
    end else if (ce_i) begin
      state     <= next_state;
      mode      <= next_mode;
      acc       <= next_acc;
      chan      <= next_chan;
      stat      <= next_stat;
      mask      <= next_mask;
      result    <= next_result;
      sar       <= next_sar;
      idx       <= next_idx;
      cnt       <= next_cnt;
      warm      <= next_warm;
      first_bad <= next_first_bad;
      rdata     <= next_rdata;
      sample    <= next_sample;
      irq       <= next_irq;
    end
  end

  // zero wait state, always okay
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  assign hrdata_o   = rdata;
  assign dac_code_o = sar;
  assign sample_o   = sample;
  assign channel_o  = chan;
  assign irq_o      = irq;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence seq_early_start;
    ce_i && (state == ST_IDLE) && mode.run && !warm_ok && !stop_mode_i && !wr_cfg;
  endsequence
  sequence seq_clean_end;
    ce_i && done && !wr_cfg && !stop_mode_i && run_now;
  endsequence
  sequence seq_sample_end;
    ce_i && (state == ST_SAMPLE) && (cnt == {2'b00, mode.fr, 3'b111}) && !wr_cfg && run_now && !stop_mode_i;
  endsequence
  sequence seq_bit_step;
    ce_i && step && !done && !wr_cfg && run_now && !stop_mode_i;
  endsequence

  a_stop_halts: assert property (ce_i && stop_mode_i |=> state == ST_IDLE)
    else $error("converter active in stop mode");
  a_read_old_result: assert property (ce_i && take && !hwrite_i && done && !wr_cfg
      && (haddr_i[7:0] == RFULL_OFS) |=> hrdata_o[9:0] == $past(result) && result == $past(sar_kept))
    else $error("result read lost priority");
  a_cfg_no_store: assert property (ce_i && done && wr_cfg |=> $stable(result))
    else $error("result stored despite config write");
  a_cfg_no_flag: assert property (ce_i && done && wr_cfg && !stat[ST_END] |=> !stat[ST_END])
    else $error("end flag raised despite config write");
  a_chan_keeps_flag: assert property (ce_i && wr_chan && stat[ST_END]
      && !(take && !hwrite_i && (haddr_i[7:0] == STAT_OFS)) |=> stat[ST_END])
    else $error("channel write cleared end flag");
  a_early_suspect: assert property (seq_early_start ##1 (state == ST_SAMPLE) |-> first_bad)
    else $error("early start not marked");
  a_end_repeats: assert property (seq_clean_end |=> stat[ST_END] && state == ST_SAMPLE && cnt == 8'h00)
    else $error("conversion end not stored or not repeated");
  a_cfg_aborts: assert property (ce_i && wr_cfg && (state == ST_CONV) |=> state != ST_CONV)
    else $error("config write did not abort");
  a_run_clear: assert property (ce_i && wr_mode && !hwdata_i[RUN_BIT] |=> state == ST_IDLE && !mode.run)
    else $error("run clear did not stop");
  a_result_hold: assert property (ce_i && !done |=> $stable(result))
    else $error("result changed without conversion end");

  // every check is gated by the enable, so a frozen cycle proves nothing
  a_end_stores: assert property (seq_clean_end
      |=> result == $past(sar_kept) && !first_bad)
    else $error("completed conversion not stored");
  a_idle_start: assert property (ce_i && (state == ST_IDLE) && mode.run && !stop_mode_i && !wr_cfg
      |=> state == ST_SAMPLE && cnt == 8'h00)
    else $error("run bit did not start conversion");
  a_sample_len: assert property (seq_sample_end
      |=> state == ST_CONV && sar == SAR_MSB_SET && idx == IDX_MSB)
    else $error("sample window did not hand over to conversion");
  a_bit_step: assert property (seq_bit_step
      |=> state == ST_CONV && idx == $past(idx) - 4'h1 && cnt == 8'h00)
    else $error("bit step did not advance");
  a_cnt_bound: assert property (ce_i && (state == ST_CONV) |-> cnt <= BIT_LAST)
    else $error("bit step counter ran past its end");
  a_sample_out: assert property (ce_i
      |=> sample_o == (state == ST_SAMPLE))
    else $error("sample output out of step with sequencer");
  a_stop_no_sample: assert property (ce_i && stop_mode_i
      |=> !sample_o && !done)
    else $error("sampling in stop mode");
  a_cfg_restart: assert property (ce_i && wr_cfg && run_now && !stop_mode_i
      |=> state == ST_SAMPLE && cnt == 8'h00)
    else $error("config write did not restart conversion");
  a_run_off_idle: assert property (ce_i && !mode.run && !wr_mode
      |=> state == ST_IDLE)
    else $error("converter ran with run bit clear");
  a_warm_reset: assert property (ce_i && !mode.ena
      |=> warm == 8'h00)
    else $error("settle count kept without power enable");
  a_susp_only_early: assert property (ce_i && !first_bad && !stat[ST_SUSP]
      |=> !stat[ST_SUSP])
    else $error("suspect flag set without early start");
  a_read_clears: assert property (ce_i && take && !hwrite_i && (haddr_i[7:0] == STAT_OFS) && !done
      |=> stat == STAT_RST)
    else $error("status read did not clear");
  a_irq_level: assert property (ce_i
      |=> irq_o == |(stat & mask))
    else $error("interrupt level out of step with status");
  a_chan_written: assert property (ce_i && wr_chan
      |=> channel_o == $past(hwdata_i[1:0]))
    else $error("channel write not applied");
endmodule : conversion_run_bit_top

// [design/conversion_run_bit_pkg.sv]
package conversion_run_bit_pkg;
  // register byte offsets
  localparam logic [7:0] MODE_OFS   = 8'h00;
  localparam logic [7:0] CHAN_OFS   = 8'h04;
  localparam logic [7:0] RFULL_OFS  = 8'h08;
  localparam logic [7:0] RUPPER_OFS = 8'h0c;
  localparam logic [7:0] STAT_OFS   = 8'h10;
  localparam logic [7:0] MASK_OFS   = 8'h14;
  // reset values and writable bits
  localparam logic [7:0] MODE_RST   = 8'h00;
  localparam logic [7:0] MODE_WMASK = 8'hb9;
  localparam logic [1:0] CHAN_RST   = 2'h0;
  localparam logic [1:0] STAT_RST   = 2'h0;
  localparam logic [1:0] MASK_RST   = 2'h0;
  // field positions
  localparam int RUN_BIT = 7;
  localparam int ST_END  = 0;
  localparam int ST_SUSP = 1;
  // converter geometry
  localparam int         RES_W       = 10;
  localparam logic [9:0] SAR_MSB_SET = 10'h200;
  localparam logic [3:0] IDX_MSB     = 4'h9;
  localparam logic [7:0] BIT_LAST    = 8'h01;
  // timing: 1 us settle after power enable
  localparam int         CLK_NS   = 10;
  localparam int         WARM_NS  = 1000;
  localparam logic [7:0] WARM_CYC = 8'((WARM_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONV   = 2'b10
  } conversion_run_bit_state_type;

  typedef struct packed {
    logic       run;
    logic       rsv6;
    logic [2:0] fr;
    logic [1:0] rsv21;
    logic       ena;
  } conversion_run_bit_mode_type;

  typedef struct packed {
    logic       vld;
    logic       wr;
    logic [7:0] addr;
  } conversion_run_bit_acc_type;
endpackage : conversion_run_bit_pkg

// [tb/conversion_run_bit_ana_model.sv]
`timescale 1ns/10ps
module conversion_run_bit_ana_model (
  // converter side
  input  wire logic [9:0]  dac_code_i,
  input  wire logic [1:0]  channel_i,
  input  wire logic [39:0] level_i,
  output logic             cmp_o
);
  // ideal comparator, no offset: result equals the input level
  // pins only ever carry analog levels: no alternate function, no port traffic
  assign cmp_o = (level_i[channel_i*10 +: 10] >= dac_code_i);
endmodule : conversion_run_bit_ana_model

// [tb/conversion_run_bit_top_tb.sv]
`timescale 1ns/10ps
module conversion_run_bit_top_tb;
  import conversion_run_bit_pkg::*;
  logic        clk_i     = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        hsel      = 1'b0;
  logic        hwrite    = 1'b0;
  logic        stop_mode = 1'b0;
  logic [1:0]  htrans    = 2'h0;
  logic [31:0] haddr     = 32'h0;
  logic [31:0] hwdata    = 32'h0;
  logic [39:0] level     = 40'h0;
  logic [31:0] seed      = 32'h00017c82;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [9:0]  dac;
  logic [9:0]  v;
  logic [1:0]  chan;
  logic        hready;
  logic        irq;
  logic        cmp;
  logic        hresp;
  logic        sample;
  int          error_cnt  = 0;
  int          num_checks = 0;

  conversion_run_bit_top conversion_run_bit_top_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .cmp_i(cmp), .stop_mode_i(stop_mode),
    .dac_code_o(dac), .sample_o(sample), .channel_o(chan), .irq_o(irq)
  );

  conversion_run_bit_ana_model conversion_run_bit_ana_model_i (
    .dac_code_i(dac), .channel_i(chan), .level_i(level), .cmp_o(cmp)
  );

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // one single word transfer; read data taken at the data phase edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk_i); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (hready !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0, "resp");
  endtask : bus

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp, "read");
  endtask : rdchk

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, irq}, 32'h1, "irq");
  endtask : wait_irq

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    chk({31'h0, irq}, 32'h0, "irq rst");
    rdchk(MODE_OFS, {24'h0, MODE_RST});
    rdchk(CHAN_OFS, {30'h0, CHAN_RST});
    rdchk(STAT_OFS, {30'h0, STAT_RST});
    rdchk(8'h40, 32'h0);
    bus(1'b1, MASK_OFS, 32'h3);
    rdchk(MASK_OFS, 32'h3);
    // early start without power enable, first result is suspect
    bus(1'b1, MODE_OFS, 32'h80);
    wait_irq();
    bus(1'b1, MODE_OFS, 32'h0);
    rdchk(STAT_OFS, 32'h3);
    rdchk(STAT_OFS, 32'h0);
    bus(1'b1, MODE_OFS, 32'h1);
    repeat (WARM_CYC + 2) @(posedge clk_i);
    for (int c = 0; c < 4; c++) begin
      seed = lfsr(seed);
      v = (c == 0) ? 10'h3ff : (c == 1) ? 10'h0 : seed[9:0];
      level[c*10 +: 10] <= v;
      bus(1'b1, CHAN_OFS, c);
      bus(1'b1, MODE_OFS, 32'h81);
      wait_irq();
      rdchk(RFULL_OFS, {22'h0, v});
      rdchk(RUPPER_OFS, {24'h0, v[9:2]});
      rdchk(STAT_OFS, 32'h1);
      wait_irq();
      rdchk(RFULL_OFS, {22'h0, v});
      rdchk(STAT_OFS, 32'h1);
    end
    // result read landing on the store edge sees the old value first
    wait_irq();
    chk({31'h0, sample}, 32'h1, "sample");
    level[30 +: 10] <= ~v;
    repeat (26) @(posedge clk_i);
    rdchk(RFULL_OFS, {22'h0, v});
    rdchk(RFULL_OFS, {22'h0, ~v});
    rdchk(STAT_OFS, 32'h1);
    // channel write in the store cycle: no store, no flag
    level[30 +: 10] <= v;
    repeat (21) @(posedge clk_i);
    bus(1'b1, CHAN_OFS, 32'h3);
    rdchk(RFULL_OFS, {22'h0, ~v});
    rdchk(STAT_OFS, 32'h0);
    chk({31'h0, irq}, 32'h0, "irq cfg");
    wait_irq();
    bus(1'b1, MODE_OFS, 32'h1);
    bus(1'b1, CHAN_OFS, 32'h0);
    rdchk(STAT_OFS, 32'h1);
    rdchk(STAT_OFS, 32'h0);
    repeat (60) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0, "irq stop");
    // deep stop holds the converter idle even with run set
    stop_mode <= 1'b1;
    // power enable dropped as well, so the release below is an early start
    bus(1'b1, MODE_OFS, 32'h80);
    repeat (100) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0, "irq deep");
    chk({31'h0, sample}, 32'h0, "sample deep");
    rdchk(STAT_OFS, 32'h0);
    stop_mode <= 1'b0;
    wait_irq();
    rdchk(RFULL_OFS, 32'h3ff);
    rdchk(STAT_OFS, 32'h3);
    tally_and_finish();
  end
endmodule : conversion_run_bit_top_tb
